//--- core/adcsic_top.sv
// Purpose: Converter status, interrupt and result handoff registers
// Assumes: Converter strobes and processor requests are synchronous
// Notes:   Read data is registered one cycle after the read strobe
//
// Overview of operation
// - Ground switch floats whenever config bit 7 is clear.
// - Ground connect set: mode bit 6 picks direct or 20k path.
// - Status bits 15..8 are flags only, never interrupt.
// - Status bits 7..0 masked per bit then ORed into one interrupt.
// - Mask bit 1 enables a source; mask resets to zero.
// - Reading the current result clears every ready bit.
// - With current converter off, voltage or temperature read clears all.
// - Unless the core sleeps, a result loads only while its ready bit is clear.
// - While the core sleeps, results load the latest value except during settling discard.
// - Calibration bit sets on calibration end, clears on mode write.
// - Over or underrange sets channel error bit and clamps result.
// - Error bit clears when an in-range result loads.
// - Comparator bit sets on threshold exceed; with count use, only on the exceed that makes the count match the limit.
// - Comparator bit clears on reconfiguration or comparator disable.
// - Overrange bit sampled every 125 us when detection enabled.
// - Overrange bit clears only on detect disable or gain change.
// - Temperature ready sets on load or calibration; temp/current read clears.
// - Voltage ready sets on load or calibration; volt/current read clears.
// - Current ready sets on load or calibration; current read clears.
// - With chopOff set, voltage/temperature first result is the third conversion after switch.
`timescale 1ns/1ps
`default_nettype none
`include "adcsic_regs.svh"

module adcsic_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Processor register access
  input wire adcsic_pkg::adcsic_bus_type busReq,
  output logic [15:0] rdData,
  // Converter results
  input wire adcsic_pkg::adcsic_conv_type curConv,
  input wire adcsic_pkg::adcsic_conv_type vltConv,
  input wire adcsic_pkg::adcsic_conv_type tmpConv,
  // Converter events
  input wire logic calDone,
  input wire logic grossOver,
  input wire logic chopOff,
  input wire logic coreAsleep,
  // Mode to converters
  output logic [7:0] convMode,
  // Interrupt
  output logic irq,
  // Ground switch pin
  output logic gndSwOut,
  output logic gndSwOeN,
  output logic gndSwViaRes
);
  import adcsic_pkg::*;

  localparam int OVR_CYC = `ADCSIC_OVR_PERIOD_NS / `ADCSIC_CLK_PERIOD_NS;
  localparam logic [10:0] OVR_LAST = 11'(OVR_CYC - 1);

  // ********************************************************
  // Register state
  // ********************************************************
  logic [7:0] mask_q;
  logic [7:0] mode_q;
  logic [7:0] cfg_q;
  logic [15:0] curCtrl_q;
  logic [15:0] vtCtrl_q;
  logic [15:0] thresh_q;
  logic [15:0] cntLim_q;
  logic [15:0] cntVal_q;
  logic [15:0] rdData_q;
  logic [2:0] rdy_q;
  logic [2:0] rdy_d;
  logic cmp_q;
  logic ovr_q;
  logic cal_q;
  logic [10:0] tick_q;
  logic curLoaded_q;

  // ********************************************************
  // Address decode
  // ********************************************************
  wire wrMask = busReq.wr && busReq.addr == `ADCSIC_OFF_MASK;
  wire wrMode = busReq.wr && busReq.addr == `ADCSIC_OFF_MODE;
  wire wrCfg = busReq.wr && busReq.addr == `ADCSIC_OFF_CONFIG;
  wire wrCur = busReq.wr && busReq.addr == `ADCSIC_OFF_CURCTRL;
  wire wrVt = busReq.wr && busReq.addr == `ADCSIC_OFF_VTCTRL;
  wire wrTh = busReq.wr && busReq.addr == `ADCSIC_OFF_THRESH;
  wire wrLim = busReq.wr && busReq.addr == `ADCSIC_OFF_CNTLIM;
  wire rdCur = busReq.rd && busReq.addr == `ADCSIC_OFF_CURDAT;
  wire rdVlt = busReq.rd && busReq.addr == `ADCSIC_OFF_VLTDAT;
  wire rdTmp = busReq.rd && busReq.addr == `ADCSIC_OFF_TMPDAT;

  // ********************************************************
  // Channel enables and reconfiguration events
  // ********************************************************
  wire curEn = curCtrl_q[`ADCSIC_CTRL_ENABLE];
  wire vtEn = vtCtrl_q[`ADCSIC_CTRL_ENABLE];
  wire gainChg = wrCur && busReq.wdata[`ADCSIC_CTRL_GAIN_HI:0] !=
                 curCtrl_q[`ADCSIC_CTRL_GAIN_HI:0];
  wire vtSwitch = wrVt &&
    busReq.wdata[`ADCSIC_VT_INSEL_HI:`ADCSIC_VT_INSEL_LO] !=
    vtCtrl_q[`ADCSIC_VT_INSEL_HI:`ADCSIC_VT_INSEL_LO];
  wire cmpEn = cfg_q[`ADCSIC_CFG_CMP_EN];
  wire cntUse = cfg_q[`ADCSIC_CFG_CNT_USE];
  wire ovrEn = cfg_q[`ADCSIC_CFG_OVR_EN];

  // ********************************************************
  // Result channels
  // ********************************************************
  wire [15:0] curRes;
  wire [15:0] vltRes;
  wire [15:0] tmpRes;
  wire [2:0] err;
  wire [2:0] loaded;

  adcsic_channel curChan (
    .clock(clock),
    .rst(rst),
    .conv(curConv),
    .restart(1'b0),
    .settleOn(1'b0),
    .ready(rdy_q[0]),
    .coreAsleep(coreAsleep),
    .result(curRes),
    .convErr(err[0]),
    .loaded(loaded[0])
  );

  adcsic_channel vltChan (
    .clock(clock),
    .rst(rst),
    .conv(vltConv),
    .restart(vtSwitch),
    .settleOn(chopOff),
    .ready(rdy_q[1]),
    .coreAsleep(coreAsleep),
    .result(vltRes),
    .convErr(err[1]),
    .loaded(loaded[1])
  );

  adcsic_channel tmpChan (
    .clock(clock),
    .rst(rst),
    .conv(tmpConv),
    .restart(vtSwitch),
    .settleOn(chopOff),
    .ready(rdy_q[2]),
    .coreAsleep(coreAsleep),
    .result(tmpRes),
    .convErr(err[2]),
    .loaded(loaded[2])
  );

  // ********************************************************
  // Ready bits
  // ********************************************************
  wire [2:0] chEn = {vtEn, vtEn, curEn};
  wire clrAll = rdCur || (!curEn && (rdVlt || rdTmp));
  wire [2:0] rdyClr = {clrAll || rdTmp, clrAll || rdVlt, clrAll || !curEn};

  generate
    for (genvar i = 0; i < 3; i++) begin : gRdy
      wire rdySet = chEn[i] && (loaded[i] || calDone);
      assign rdy_d[i] = rdySet || (rdy_q[i] && !rdyClr[i]);
    end
  endgenerate

  // ********************************************************
  // Comparator
  // ********************************************************
  wire [15:0] absCur = curRes[15] ? 16'(~curRes + 16'h0001) : curRes;
  wire exceed = curLoaded_q && (absCur > thresh_q);
  wire [15:0] cntNext = 16'(cntVal_q + 16'h0001);
  wire cmpSet = cmpEn && exceed && (!cntUse || cntNext == cntLim_q);
  wire cmpClr = !cmpEn || wrCur || wrVt;

  // ********************************************************
  // Overrange sampling
  // ********************************************************
  wire tick = tick_q == OVR_LAST;
  wire ovrSet = tick && ovrEn && grossOver;
  wire ovrClr = !ovrEn || gainChg;

  // ********************************************************
  // Status word and interrupt
  // ********************************************************
  wire [15:0] status = {cal_q, err[2], err[1], err[0], 7'h00,
                        cmp_q, ovr_q, rdy_q};
  assign irq = |(status[7:0] & mask_q);

  // ********************************************************
  // Read multiplexer
  // ********************************************************
  wire [31:0] ra = busReq.addr;
  wire [15:0] rdMux =
    ra == `ADCSIC_OFF_STATUS ? status :
    ra == `ADCSIC_OFF_MASK ? {8'h00, mask_q} :
    ra == `ADCSIC_OFF_MODE ? {8'h00, mode_q} :
    ra == `ADCSIC_OFF_CONFIG ? {8'h00, cfg_q} :
    ra == `ADCSIC_OFF_CURCTRL ? curCtrl_q :
    ra == `ADCSIC_OFF_VTCTRL ? vtCtrl_q :
    ra == `ADCSIC_OFF_CURDAT ? curRes :
    ra == `ADCSIC_OFF_VLTDAT ? vltRes :
    ra == `ADCSIC_OFF_TMPDAT ? tmpRes :
    ra == `ADCSIC_OFF_THRESH ? thresh_q :
    ra == `ADCSIC_OFF_CNTVAL ? cntVal_q :
    ra == `ADCSIC_OFF_CNTLIM ? cntLim_q : 16'h0000;

  // ********************************************************
  // Configuration registers
  // ********************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q <= `ADCSIC_RST_MASK;
      mode_q <= `ADCSIC_RST_MODE;
      cfg_q <= `ADCSIC_RST_CONFIG;
      curCtrl_q <= `ADCSIC_RST_WORD;
      vtCtrl_q <= `ADCSIC_RST_WORD;
      thresh_q <= `ADCSIC_RST_WORD;
      cntLim_q <= `ADCSIC_RST_WORD;
      rdData_q <= `ADCSIC_RST_WORD;
    end else begin
      if (wrMask) mask_q <= busReq.wdata[7:0];
      if (wrMode) mode_q <= busReq.wdata[7:0];
      if (wrCfg) cfg_q <= busReq.wdata[7:0];
      if (wrCur) curCtrl_q <= busReq.wdata;
      if (wrVt) vtCtrl_q <= busReq.wdata;
      if (wrTh) thresh_q <= busReq.wdata;
      if (wrLim) cntLim_q <= busReq.wdata;
      if (busReq.rd) rdData_q <= rdMux;
    end
  end

  // ********************************************************
  // Status flags
  // ********************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdy_q <= 3'h0;
      cmp_q <= 1'b0;
      ovr_q <= 1'b0;
      cal_q <= 1'b0;
      tick_q <= 11'h000;
      cntVal_q <= `ADCSIC_RST_WORD;
      curLoaded_q <= 1'b0;
    end else begin
      rdy_q <= rdy_d;
      cmp_q <= cmpSet || (cmp_q && !cmpClr);
      ovr_q <= ovrSet || (ovr_q && !ovrClr);
      cal_q <= calDone || (cal_q && !wrMode);
      tick_q <= tick ? 11'h000 : 11'(tick_q + 11'h001);
      curLoaded_q <= loaded[0];
      if (cmpClr || cmpSet) cntVal_q <= `ADCSIC_RST_WORD;
      else if (cmpEn && exceed) cntVal_q <= cntNext;
    end
  end

  // ********************************************************
  // Outputs and ground switch
  // ********************************************************
  assign rdData = rdData_q;
  assign convMode = mode_q;

  adcsic_gnd_switch gndSw (
    .gndConnect(cfg_q[`ADCSIC_CFG_GND_CONNECT]),
    .resSel(mode_q[`ADCSIC_MODE_RES_SEL]),
    .pinOut(gndSwOut),
    .pinOeN(gndSwOeN),
    .viaRes(gndSwViaRes)
  );
endmodule
`default_nettype wire

//--- core/adcsic_regs.svh
// Purpose: Offsets, field positions, reset values and timing constants
// Assumes: Processor addresses are full 32-bit byte addresses
// Notes:   Definitions only
`ifndef ADCSIC_REGS_SVH
`define ADCSIC_REGS_SVH

// ********************************************************
// Register addresses
// ********************************************************
`define ADCSIC_OFF_STATUS 32'hFFFF0500
`define ADCSIC_OFF_MASK 32'hFFFF0504
`define ADCSIC_OFF_MODE 32'hFFFF0508
`define ADCSIC_OFF_CURCTRL 32'hFFFF050C
`define ADCSIC_OFF_VTCTRL 32'hFFFF0510
`define ADCSIC_OFF_CURDAT 32'hFFFF0520
`define ADCSIC_OFF_VLTDAT 32'hFFFF0524
`define ADCSIC_OFF_TMPDAT 32'hFFFF0528
`define ADCSIC_OFF_CONFIG 32'hFFFF0530
`define ADCSIC_OFF_THRESH 32'hFFFF0534
`define ADCSIC_OFF_CNTVAL 32'hFFFF0538
`define ADCSIC_OFF_CNTLIM 32'hFFFF053C

// ********************************************************
// Reset values
// ********************************************************
`define ADCSIC_RST_MASK 8'h00
`define ADCSIC_RST_MODE 8'h00
`define ADCSIC_RST_CONFIG 8'h00
`define ADCSIC_RST_WORD 16'h0000

// ********************************************************
// Field positions
// ********************************************************
`define ADCSIC_CFG_GND_CONNECT 7
`define ADCSIC_CFG_OVR_EN 2
`define ADCSIC_CFG_CNT_USE 1
`define ADCSIC_CFG_CMP_EN 0
`define ADCSIC_MODE_RES_SEL 6
`define ADCSIC_CTRL_ENABLE 15
`define ADCSIC_CTRL_GAIN_HI 3
`define ADCSIC_VT_INSEL_HI 7
`define ADCSIC_VT_INSEL_LO 6

// ********************************************************
// Result clamps and timing
// ********************************************************
`define ADCSIC_POS_FULL 16'h7FFF
`define ADCSIC_NEG_FULL 16'h8000
`define ADCSIC_VT_DISCARD 2'h2
`define ADCSIC_CLK_PERIOD_NS 100
`define ADCSIC_OVR_PERIOD_NS 125000

`endif

//--- core/adcsic_pkg.sv
// Purpose: Types shared by the converter status block
// Assumes: Nothing
// Notes:   Constants live in adcsic_regs.svh
package adcsic_pkg;

  // ********************************************************
  // Converter result strobe
  // ********************************************************
  typedef struct packed {
    logic valid;
    logic over;
    logic under;
    logic [15:0] data;
  } adcsic_conv_type;

  // ********************************************************
  // Processor register request
  // ********************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [15:0] wdata;
  } adcsic_bus_type;

endpackage

//--- core/adcsic_channel.sv
// Purpose: One result register with clamp, error flag and load gating
// Assumes: conv.valid is a one-cycle pulse
// Notes:   Settling discard only starts when settleOn is high
`timescale 1ns/1ps
`default_nettype none
`include "adcsic_regs.svh"

module adcsic_channel (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Converter side
  input wire adcsic_pkg::adcsic_conv_type conv,
  input wire logic restart,
  input wire logic settleOn,
  // Status side
  input wire logic ready,
  input wire logic coreAsleep,
  output logic [15:0] result,
  output logic convErr,
  output logic loaded
);
  import adcsic_pkg::*;

  logic [1:0] discard_q;
  logic [1:0] discard_d;
  logic [15:0] result_q;
  logic err_q;
  wire accept = conv.valid && (discard_q == 2'h0);
  wire isErr = conv.over || conv.under;
  wire [15:0] clamped = conv.over ? `ADCSIC_POS_FULL :
                        conv.under ? `ADCSIC_NEG_FULL : conv.data;

  // ********************************************************
  // Settling discard after an input switch
  // ********************************************************
  assign discard_d = (restart && settleOn) ? `ADCSIC_VT_DISCARD :
                     (conv.valid && discard_q != 2'h0) ?
                     discard_q - 2'h1 : discard_q;

  // ********************************************************
  // Result load gating
  // ********************************************************
  assign loaded = accept && (!ready || coreAsleep);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      discard_q <= 2'h0;
      result_q <= `ADCSIC_RST_WORD;
      err_q <= 1'b0;
    end else begin
      discard_q <= discard_d;
      if (loaded) begin
        result_q <= clamped;
        err_q <= isErr;
      end
    end
  end

  assign result = result_q;
  assign convErr = err_q;
endmodule
`default_nettype wire

//--- core/adcsic_gnd_switch.sv
// Purpose: Ground switch pin control
// Assumes: Pin is a switch to ground, never driven high
// Notes:   Output enable is low while the switch conducts
`timescale 1ns/1ps
`default_nettype none

module adcsic_gnd_switch (
  // Configuration
  input wire logic gndConnect,
  input wire logic resSel,
  // Pin
  output logic pinOut,
  output logic pinOeN,
  output logic viaRes
);
  // ********************************************************
  // Switch paths
  // ********************************************************
  assign pinOut = 1'b0;
  assign pinOeN = !gndConnect;
  assign viaRes = gndConnect && resSel;
endmodule
`default_nettype wire

//--- verif/adcsic_checker.sv
// Purpose: Port assertions for the converter status block
// Assumes: One clock domain, rst async active high
// Notes:   Mask value is tracked from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "adcsic_regs.svh"

module adcsic_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Observed ports
  input wire adcsic_pkg::adcsic_bus_type busReq,
  input wire logic [15:0] rdData,
  input wire adcsic_pkg::adcsic_conv_type curConv,
  input wire adcsic_pkg::adcsic_conv_type vltConv,
  input wire adcsic_pkg::adcsic_conv_type tmpConv,
  input wire logic calDone,
  input wire logic [7:0] convMode,
  input wire logic irq,
  input wire logic gndSwOut,
  input wire logic gndSwOeN
);
  import adcsic_pkg::*;
  // ****
  // Decode
  // ****
  logic [7:0] mask_q;
  wire quiet = !curConv.valid && !vltConv.valid && !tmpConv.valid && !calDone;
  wire wrCfg = busReq.wr && busReq.addr == `ADCSIC_OFF_CONFIG;
  wire wrMode = busReq.wr && busReq.addr == `ADCSIC_OFF_MODE;
  wire wrMask = busReq.wr && busReq.addr == `ADCSIC_OFF_MASK;
  wire rdSt = busReq.rd && busReq.addr == `ADCSIC_OFF_STATUS;
  wire rdCur = busReq.rd && busReq.addr == `ADCSIC_OFF_CURDAT;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q <= 8'h00;
    end else if (wrMask) begin
      mask_q <= busReq.wdata[7:0];
    end
  end

  property p_float;
    wrCfg && !busReq.wdata[7] |=> gndSwOeN && !gndSwOut;
  endproperty
  a_float: assert property (p_float) else $error("pin not floating");
  property p_direct;
    wrCfg && busReq.wdata[7] |=> !gndSwOeN && !gndSwOut;
  endproperty
  a_direct: assert property (p_direct) else $error("pin not to ground");
  property p_mode;
    wrMode |=> convMode == $past(busReq.wdata[7:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not taken");
  property p_rst;
    $fell(rst) |-> rdData == 16'h0000 && !irq && convMode == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_irqmask;
    mask_q == 8'h00 |-> !irq;
  endproperty
  a_irqmask: assert property (p_irqmask) else $error("irq while masked");
  property p_irqhold;
    irq && !busReq.rd && !busReq.wr |=> irq;
  endproperty
  a_irqhold: assert property (p_irqhold) else $error("irq dropped");
  property p_rdclr;
    rdCur && quiet ##1 quiet ##1 rdSt |=> rdData[2:0] == 3'h0;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("ready not cleared");
  property p_calset;
    calDone ##1 !wrMode ##1 rdSt |=> rdData[15];
  endproperty
  a_calset: assert property (p_calset) else $error("cal bit not set");
  property p_calclr;
    wrMode && !calDone ##1 !calDone ##1 rdSt |=> !rdData[15];
  endproperty
  a_calclr: assert property (p_calclr) else $error("cal bit stuck");

  c_cal: cover property (calDone);
  c_over: cover property (curConv.valid && curConv.over);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

//--- verif/adcsic_conv_model.sv
// Purpose: Converter side model driving result strobes
// Assumes: Bench commands one pulse at a time
// Notes:   Idle data toggles so stale values never look valid
`timescale 1ns/1ps
`default_nettype none

module adcsic_conv_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bench commands
  input wire logic [2:0] fire,
  input wire adcsic_pkg::adcsic_conv_type cmd,
  // Strobes to the block
  output var adcsic_pkg::adcsic_conv_type curConv,
  output var adcsic_pkg::adcsic_conv_type vltConv,
  output var adcsic_pkg::adcsic_conv_type tmpConv
);
  import adcsic_pkg::*;

  function automatic adcsic_conv_type nxt(input logic f,
    input adcsic_conv_type last);
    nxt = f ? cmd : adcsic_conv_type'({3'h0, ~last.data});
  endfunction

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      curConv <= '0;
      vltConv <= '0;
      tmpConv <= '0;
    end else begin
      curConv <= nxt(fire[0], curConv);
      vltConv <= nxt(fire[1], vltConv);
      tmpConv <= nxt(fire[2], tmpConv);
    end
  end
endmodule
`default_nettype wire

//--- verif/adcsic_top_tb.sv
// Purpose: Scenario bench for the converter status block
// Assumes: Two-cycle bus tasks, inputs driven 1 ns after the edge
// Notes:   Overrange waits span the fixed sampling period
`timescale 1ns/1ps
`default_nettype none
`include "adcsic_regs.svh"

module adcsic_top_tb;
  import adcsic_pkg::*;
  localparam logic [31:0] ST = `ADCSIC_OFF_STATUS;
  localparam logic [31:0] MK = `ADCSIC_OFF_MASK;
  localparam logic [31:0] MD = `ADCSIC_OFF_MODE;
  localparam logic [31:0] CC = `ADCSIC_OFF_CURCTRL;
  localparam logic [31:0] VC = `ADCSIC_OFF_VTCTRL;
  localparam logic [31:0] CD = `ADCSIC_OFF_CURDAT;
  localparam logic [31:0] VD = `ADCSIC_OFF_VLTDAT;
  localparam logic [31:0] TD = `ADCSIC_OFF_TMPDAT;
  localparam logic [31:0] CF = `ADCSIC_OFF_CONFIG;
  localparam logic [31:0] TH = `ADCSIC_OFF_THRESH;
  localparam logic [31:0] CL = `ADCSIC_OFF_CNTLIM;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic calDone = 1'b0;
  logic grossOver = 1'b0;
  logic chopOff = 1'b0;
  logic coreAsleep = 1'b0;
  logic [2:0] fire = 3'h0;
  adcsic_bus_type busReq = '0;
  adcsic_conv_type cmd = '0;
  adcsic_conv_type curConv, vltConv, tmpConv;
  logic [15:0] rdData;
  logic [7:0] convMode;
  logic irq, gndSwOut, gndSwOeN, gndSwViaRes;
  int fails = 0;
  int n_tests = 0;

  always #50 clock = ~clock;

  adcsic_conv_model conv_u (.clock(clock), .rst(rst), .fire(fire),
    .cmd(cmd), .curConv(curConv), .vltConv(vltConv), .tmpConv(tmpConv));
  adcsic_top dut_u (.clock(clock), .rst(rst), .busReq(busReq),
    .rdData(rdData), .curConv(curConv), .vltConv(vltConv),
    .tmpConv(tmpConv), .calDone(calDone), .grossOver(grossOver),
    .chopOff(chopOff), .coreAsleep(coreAsleep), .convMode(convMode),
    .irq(irq), .gndSwOut(gndSwOut), .gndSwOeN(gndSwOeN),
    .gndSwViaRes(gndSwViaRes));

  // ****
  // Tasks
  // ****
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [31:0] a,
    input logic [15:0] d);
    @(posedge clock);
    #1;
    busReq = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock);
    #1;
    busReq = '0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk(rdData, e);
  endtask
  task automatic cv(input logic [2:0] f, input logic [15:0] d,
    input logic [1:0] ou);
    @(posedge clock);
    #1;
    fire = f;
    cmd = '{valid: 1'b1, over: ou[1], under: ou[0], data: d};
    @(posedge clock);
    #1;
    fire = 3'h0;
    @(posedge clock);
  endtask
  task automatic bit1(input logic s, input logic e);
    chk({15'h0000, s}, {15'h0000, e});
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rd(ST, 16'h0000);
    rd(MK, 16'h0000);
    rd(MD, 16'h0000);
    rd(ST + 32'h40, 16'h0000);
    bit1(gndSwOeN, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_gnd;
    for (int i = 0; i < 4; i++) begin
      wr(CF, {8'h00, i[1], 7'h00});
      wr(MD, {9'h000, i[0], 6'h00});
      bit1(gndSwOeN, !i[1]);
      bit1(gndSwOut, 1'b0);
      chk({8'h00, convMode}, {9'h000, i[0], 6'h00});
      if (i[1]) bit1(gndSwViaRes, i[0]);
    end
    wr(CF, 16'h0000);
    wr(MD, 16'h0000);
    $display("test ground switch done");
  endtask
  task automatic t_ready;
    wr(CC, 16'h8000);
    wr(VC, 16'h8000);
    wr(MK, 16'h0001);
    cv(3'h1, 16'h0123, 2'h0);
    rd(ST, 16'h0001);
    bit1(irq, 1'b1);
    cv(3'h1, 16'h0456, 2'h0);
    rd(VD, 16'h0000);
    rd(ST, 16'h0001);
    rd(CD, 16'h0123);
    rd(ST, 16'h0000);
    bit1(irq, 1'b0);
    $display("test ready done");
  endtask
  task automatic t_vt;
    cv(3'h2, 16'h0111, 2'h0);
    cv(3'h4, 16'h0222, 2'h0);
    rd(ST, 16'h0006);
    rd(VD, 16'h0111);
    rd(ST, 16'h0004);
    rd(CD, 16'h0123);
    rd(ST, 16'h0000);
    rd(TD, 16'h0222);
    wr(CC, 16'h0000);
    cv(3'h2, 16'h0333, 2'h0);
    cv(3'h4, 16'h0444, 2'h0);
    rd(TD, 16'h0444);
    rd(ST, 16'h0000);
    wr(CC, 16'h8000);
    $display("test voltage temperature done");
  endtask
  task automatic t_err;
    cv(3'h1, 16'h1234, 2'h2);
    rd(ST, 16'h1001);
    rd(CD, `ADCSIC_POS_FULL);
    cv(3'h1, 16'h1234, 2'h1);
    rd(CD, `ADCSIC_NEG_FULL);
    cv(3'h1, 16'h0055, 2'h0);
    rd(ST, 16'h0001);
    rd(CD, 16'h0055);
    coreAsleep = 1'b1;
    cv(3'h1, 16'h0A0A, 2'h0);
    cv(3'h1, 16'h0B0B, 2'h0);
    rd(CD, 16'h0B0B);
    coreAsleep = 1'b0;
    $display("test error and sleep done");
  endtask
  task automatic t_cal;
    wr(MK, 16'h00FF);
    @(posedge clock);
    #1;
    calDone = 1'b1;
    @(posedge clock);
    #1;
    calDone = 1'b0;
    rd(ST, 16'h8007);
    chk(rdData & 16'hF01F, 16'h8007);
    bit1(irq, 1'b1);
    rd(CD, 16'h0B0B);
    rd(ST, 16'h8000);
    bit1(irq, 1'b0);
    wr(MD, 16'h0000);
    rd(ST, 16'h0000);
    wr(MK, 16'h0001);
    $display("test calibration done");
  endtask
  task automatic t_cmp;
    wr(TH, 16'h0100);
    wr(CF, 16'h0001);
    cv(3'h1, 16'hFE00, 2'h0);
    rd(ST, 16'h0011);
    rd(CD, 16'hFE00);
    wr(CC, 16'h8000);
    rd(ST, 16'h0000);
    cv(3'h1, 16'h0200, 2'h0);
    rd(CD, 16'h0200);
    rd(ST, 16'h0010);
    wr(CF, 16'h0000);
    rd(ST, 16'h0000);
    wr(CL, 16'h0002);
    wr(CF, 16'h0003);
    cv(3'h1, 16'h0200, 2'h0);
    rd(CD, 16'h0200);
    rd(ST, 16'h0000);
    cv(3'h1, 16'h0300, 2'h0);
    rd(CD, 16'h0300);
    rd(ST, 16'h0010);
    wr(CF, 16'h0000);
    rd(ST, 16'h0000);
    $display("test comparator done");
  endtask
  task automatic t_ovr;
    grossOver = 1'b1;
    wr(CF, 16'h0004);
    repeat (1300) @(posedge clock);
    rd(ST, 16'h0008);
    grossOver = 1'b0;
    repeat (1300) @(posedge clock);
    rd(ST, 16'h0008);
    wr(CF, 16'h0000);
    rd(ST, 16'h0000);
    grossOver = 1'b1;
    wr(CF, 16'h0004);
    repeat (1300) @(posedge clock);
    rd(ST, 16'h0008);
    grossOver = 1'b0;
    wr(CC, 16'h8001);
    rd(ST, 16'h0000);
    wr(CF, 16'h0000);
    chopOff = 1'b1;
    wr(VC, 16'h8040);
    cv(3'h2, 16'h0701, 2'h0);
    cv(3'h2, 16'h0702, 2'h0);
    rd(ST, 16'h0000);
    cv(3'h2, 16'h0703, 2'h0);
    rd(VD, 16'h0703);
    $display("test overrange and settling done");
  endtask
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    t_reset();
    t_gnd();
    t_ready();
    t_vt();
    t_err();
    t_cal();
    t_cmp();
    t_ovr();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    test_done();
  end
endmodule

bind adcsic_top adcsic_checker chk_u (.clock(clock), .rst(rst),
  .busReq(busReq), .rdData(rdData), .curConv(curConv),
  .vltConv(vltConv), .tmpConv(tmpConv), .calDone(calDone),
  .convMode(convMode), .irq(irq), .gndSwOut(gndSwOut),
  .gndSwOeN(gndSwOeN));
`default_nettype wire
